//--- verilog/vesr_pkg.sv
// Constants for the virtual error syndrome register block
package vesr_pkg;
	// ----------------------------------------
	// Privilege levels
	// ----------------------------------------
	localparam logic [1:0] LVL_USER = 2'h0;
	localparam logic [1:0] LVL_KERNEL = 2'h1;
	localparam logic [1:0] LVL_HYP = 2'h2;
	localparam logic [1:0] LVL_MON = 2'h3;
	// ----------------------------------------
	// Register encodings {op1, crn, crm, op2}
	// ----------------------------------------
	localparam logic [1:0] OP0_SYSREG = 2'h3;
	localparam logic [3:0] COPROC_SYSREG = 4'hF;
	localparam logic [13:0] ENC_STATUS_VIEW = {3'h0, 4'h5, 4'h4, 3'h2};
	localparam logic [13:0] ENC_VDEFER = {3'h4, 4'hC, 4'h1, 3'h1};
	localparam logic [13:0] ENC_VSYND = {3'h4, 4'h5, 4'h2, 3'h3};
	localparam logic [13:0] ENC_PDEFER = {3'h0, 4'hC, 4'h1, 3'h1};
	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int SYN_W = 25;
	localparam int DEFER_FLAG_BIT = 31;
	localparam logic [5:0] STATUS_LONG = 6'h11;
	localparam logic [4:0] FS_SHORT = 5'h16;
	localparam logic [24:0] AA32_VSYND_KEEP = 25'h000D000;
	localparam logic [24:0] AA32_VDEFER_KEEP = 25'h000D63F;
	localparam logic [24:0] VDEFER_SYN_RST = 25'h0000000;
	localparam logic [24:0] VSYND_RST = 25'h0000000;
endpackage

//--- verilog/vesr_fmt_if.sv
// Carrier between the register core and the syndrome formatter
`timescale 1ns/100ps
`default_nettype none
interface vesr_fmt_if;
	logic [24:0] vsynd;
	logic guest_aa64;
	logic long_desc;
	logic [24:0] defer_syn;
	logic [24:0] esr_syn;
	logic [31:0] data_fault_status_reg;
	modport fmt(input vsynd, input guest_aa64, input long_desc,
		output defer_syn, output esr_syn, output data_fault_status_reg);
	modport core(output vsynd, output guest_aa64, output long_desc,
		input defer_syn, input esr_syn, input data_fault_status_reg);
endinterface
`default_nettype wire

//--- verilog/vesr_fmt.sv
// Syndrome formatter for deferral and exception entry
`timescale 1ns/100ps
`default_nettype none
module vesr_fmt (
	vesr_fmt_if.fmt f
);
	logic [24:0] aa32;

	always_comb begin
		aa32 = 25'h0000000;
		aa32[15:14] = f.vsynd[15:14];
		aa32[12] = f.vsynd[12];
		aa32[9] = f.long_desc;
		if (f.long_desc) begin
			aa32[5:0] = vesr_pkg::STATUS_LONG;
		end else begin
			{aa32[10], aa32[3:0]} = vesr_pkg::FS_SHORT;
		end
	end

	// 64-bit guest takes flag and field straight across
	assign f.defer_syn = f.guest_aa64 ? f.vsynd : aa32;
	assign f.esr_syn = f.vsynd;
	assign f.data_fault_status_reg = {7'h00, aa32};
endmodule
`default_nettype wire

//--- verilog/vesr_core.sv
// Virtual error syndrome, deferred status and selected record status view
`timescale 1ns/100ps
`default_nettype none
module vesr_core #(
	parameter int SEL_W = 16
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic NRST_I,
	// Configuration
	input wire logic RAS_PRESENT_I,
	input wire logic HYP_PRESENT_I,
	input wire logic MON_PRESENT_I,
	input wire logic HYP_ERROR_REG_TRAP_I,
	input wire logic MONITOR_ERROR_REG_TRAP_I,
	input wire logic HYP_ASYNC_ABORT_ROUTE_I,
	input wire logic GUEST_AA64_I,
	input wire logic GUEST_LONG_DESC_I,
	// System register request
	input wire logic REQ_VALID_I,
	input wire logic REQ_WRITE_I,
	input wire logic REQ_AA32_I,
	input wire logic [1:0] REQ_OP0_I,
	input wire logic [3:0] REQ_CP_I,
	input wire logic [13:0] REQ_ENC_I,
	input wire logic [1:0] REQ_LEVEL_I,
	input wire logic REQ_NONSECURE_I,
	input wire logic [63:0] REQ_WDATA_I,
	// System register answer
	output logic RESP_VALID_O,
	output logic [63:0] RESP_RDATA_O,
	output logic RESP_UNDEF_O,
	output logic RESP_TRAP_HYP_O,
	output logic RESP_TRAP_MON_O,
	output logic RESP_MISS_O,
	// Error record store
	input wire logic [SEL_W-1:0] RECORD_SELECTOR_I,
	input wire logic [SEL_W:0] RECORD_COUNT_I,
	input wire logic [63:0] REC_RDATA_I,
	output logic REC_WR_O,
	output logic [SEL_W-1:0] REC_INDEX_O,
	output logic [63:0] REC_WDATA_O,
	// Deferral and exception events
	input wire logic ESB_DEFER_I,
	input wire logic VSERR_TAKE_I,
	output logic VDEFER_FLAG_O,
	output logic EXC_VALID_O,
	output logic [24:0] EXC_ESR_SYN_O,
	output logic [31:0] EXC_DATA_FAULT_STATUS_REG_O
);
	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (SEL_W < 1 || SEL_W > 16) begin : g_bad_sel
		$error("SEL_W must lie between 1 and 16");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic resp_valid;
		logic [63:0] resp_rdata;
		logic resp_undef;
		logic resp_trap_hyp;
		logic resp_trap_mon;
		logic resp_miss;
		logic rec_wr;
		logic [SEL_W-1:0] rec_index;
		logic [63:0] rec_wdata;
		logic vdefer_flag;
		logic [24:0] vdefer_syn;
		logic [24:0] vsynd;
		logic exc_valid;
		logic [24:0] exc_esr;
		logic [31:0] exc_data_fault_status_reg;
	} vesr_state_t;

	vesr_state_t st;
	vesr_state_t next_st;
	vesr_fmt_if fmt_bus ();

	// Keeps only the bits that exist for the guest state
	function automatic logic [24:0] keep_bits(input logic aa64, input logic deferred,
			input logic [24:0] v);
		logic [24:0] m;
		m = deferred ? vesr_pkg::AA32_VDEFER_KEEP : vesr_pkg::AA32_VSYND_KEEP;
		keep_bits = aa64 ? v : (v & m);
	endfunction

	// ----------------------------------------
	// Formatter
	// ----------------------------------------
	assign fmt_bus.vsynd = st.vsynd;
	assign fmt_bus.guest_aa64 = GUEST_AA64_I;
	assign fmt_bus.long_desc = GUEST_LONG_DESC_I;

	vesr_fmt u_fmt (
		.f(fmt_bus.fmt)
	);

	// ----------------------------------------
	// Request decode
	// ----------------------------------------
	logic space_ok;
	logic is_status;
	logic is_vdefer;
	logic is_vsynd;
	logic redirect;
	logic req_mine;
	logic virt_target;
	logic out_of_range;
	logic hyp_trap;
	logic mon_trap;
	logic deny;
	logic virt_raz;

	assign space_ok = REQ_AA32_I ? (REQ_CP_I == vesr_pkg::COPROC_SYSREG)
		: (REQ_OP0_I == vesr_pkg::OP0_SYSREG);
	assign is_status = space_ok && REQ_ENC_I == vesr_pkg::ENC_STATUS_VIEW;
	assign is_vdefer = space_ok && REQ_ENC_I == vesr_pkg::ENC_VDEFER;
	assign is_vsynd = space_ok && REQ_ENC_I == vesr_pkg::ENC_VSYND;
	// Physical deferred register is only ours when routed to the virtual copy
	assign redirect = space_ok && REQ_ENC_I == vesr_pkg::ENC_PDEFER && HYP_PRESENT_I
		&& HYP_ASYNC_ABORT_ROUTE_I && REQ_NONSECURE_I
		&& REQ_LEVEL_I == vesr_pkg::LVL_KERNEL;
	assign req_mine = is_status || is_vdefer || is_vsynd || redirect;
	assign virt_target = is_vdefer || redirect;
	assign deny = !RAS_PRESENT_I
		|| REQ_LEVEL_I == vesr_pkg::LVL_USER
		|| ((is_vdefer || is_vsynd) && REQ_LEVEL_I == vesr_pkg::LVL_KERNEL);
	assign hyp_trap = is_status && HYP_PRESENT_I && HYP_ERROR_REG_TRAP_I
		&& REQ_NONSECURE_I && REQ_LEVEL_I == vesr_pkg::LVL_KERNEL;
	assign mon_trap = is_status && MON_PRESENT_I && MONITOR_ERROR_REG_TRAP_I
		&& (REQ_LEVEL_I == vesr_pkg::LVL_KERNEL || REQ_LEVEL_I == vesr_pkg::LVL_HYP);
	assign out_of_range = RECORD_COUNT_I == '0
		|| {1'b0, RECORD_SELECTOR_I} >= RECORD_COUNT_I;
	assign virt_raz = !HYP_PRESENT_I && REQ_LEVEL_I == vesr_pkg::LVL_MON;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [63:0] wd;
		next_st = st;
		wd = REQ_AA32_I ? {32'h0, REQ_WDATA_I[31:0]} : REQ_WDATA_I;
		next_st.resp_valid = REQ_VALID_I;
		next_st.resp_rdata = 64'h0;
		next_st.resp_undef = 1'b0;
		next_st.resp_trap_hyp = 1'b0;
		next_st.resp_trap_mon = 1'b0;
		next_st.resp_miss = REQ_VALID_I && !req_mine;
		next_st.rec_wr = 1'b0;
		next_st.exc_valid = 1'b0;

		if (REQ_VALID_I && req_mine) begin
			if (deny) begin
				next_st.resp_undef = 1'b1;
			end else if (is_status) begin
				// Hypervisor trap ranks above the monitor trap
				if (hyp_trap) begin
					next_st.resp_trap_hyp = 1'b1;
				end else if (mon_trap) begin
					next_st.resp_trap_mon = 1'b1;
				end else if (out_of_range) begin
					next_st.resp_rdata = 64'h0;
				end else if (REQ_WRITE_I) begin
					next_st.rec_wr = 1'b1;
					next_st.rec_index = RECORD_SELECTOR_I;
					next_st.rec_wdata = wd;
				end else begin
					next_st.resp_rdata = REC_RDATA_I;
				end
			end else if (virt_raz) begin
				next_st.resp_rdata = 64'h0;
			end else if (REQ_WRITE_I) begin
				if (virt_target) begin
					next_st.vdefer_flag = wd[vesr_pkg::DEFER_FLAG_BIT];
					next_st.vdefer_syn = keep_bits(GUEST_AA64_I, 1'b1, wd[24:0]);
				end else begin
					next_st.vsynd = keep_bits(GUEST_AA64_I, 1'b0, wd[24:0]);
				end
			end
		end

		// Deferral beats a same-cycle software write
		if (ESB_DEFER_I && RAS_PRESENT_I) begin
			next_st.vdefer_flag = 1'b1;
			next_st.vdefer_syn = fmt_bus.defer_syn;
		end

		// Reads see the value a same-cycle barrier leaves behind
		if (REQ_VALID_I && req_mine && !deny && !is_status && !virt_raz && !REQ_WRITE_I) begin
			if (virt_target) begin
				next_st.resp_rdata = {32'h0, next_st.vdefer_flag, 6'h00,
					next_st.vdefer_syn};
			end else begin
				next_st.resp_rdata = {39'h0, st.vsynd};
			end
		end

		if (VSERR_TAKE_I) begin
			next_st.exc_valid = 1'b1;
			next_st.exc_esr = GUEST_AA64_I ? fmt_bus.esr_syn : 25'h0000000;
			next_st.exc_data_fault_status_reg = GUEST_AA64_I ? 32'h0 : fmt_bus.data_fault_status_reg;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLOCK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st <= '0;
			st.vdefer_syn <= vesr_pkg::VDEFER_SYN_RST;
			st.vsynd <= vesr_pkg::VSYND_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign RESP_VALID_O = st.resp_valid;
	assign RESP_RDATA_O = st.resp_rdata;
	assign RESP_UNDEF_O = st.resp_undef;
	assign RESP_TRAP_HYP_O = st.resp_trap_hyp;
	assign RESP_TRAP_MON_O = st.resp_trap_mon;
	assign RESP_MISS_O = st.resp_miss;
	assign REC_WR_O = st.rec_wr;
	assign REC_INDEX_O = st.rec_index;
	assign REC_WDATA_O = st.rec_wdata;
	assign VDEFER_FLAG_O = st.vdefer_flag;
	assign EXC_VALID_O = st.exc_valid;
	assign EXC_ESR_SYN_O = st.exc_esr;
	assign EXC_DATA_FAULT_STATUS_REG_O = st.exc_data_fault_status_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!NRST_I);

	property p_out_of_range_zero;
		(REQ_VALID_I && is_status && !REQ_WRITE_I && !deny && !hyp_trap && !mon_trap
			&& out_of_range) |=> (RESP_VALID_O && RESP_RDATA_O == 64'h0 && !REC_WR_O);
	endproperty
	a_out_of_range_zero: assert property (p_out_of_range_zero)
		else $error("out of range status view access not read as zero");

	property p_hyp_trap;
		(REQ_VALID_I && RAS_PRESENT_I && is_status && HYP_PRESENT_I && HYP_ERROR_REG_TRAP_I
			&& REQ_NONSECURE_I && REQ_LEVEL_I == vesr_pkg::LVL_KERNEL)
			|=> (RESP_TRAP_HYP_O && !RESP_TRAP_MON_O && !REC_WR_O);
	endproperty
	a_hyp_trap: assert property (p_hyp_trap)
		else $error("status view access not trapped to hypervisor");

	property p_mon_trap;
		(REQ_VALID_I && RAS_PRESENT_I && is_status && !hyp_trap && MON_PRESENT_I
			&& MONITOR_ERROR_REG_TRAP_I && REQ_LEVEL_I == vesr_pkg::LVL_HYP)
			|=> RESP_TRAP_MON_O;
	endproperty
	a_mon_trap: assert property (p_mon_trap)
		else $error("status view access not trapped to monitor");

	property p_user_undef;
		(REQ_VALID_I && req_mine && REQ_LEVEL_I == vesr_pkg::LVL_USER)
			|=> (RESP_VALID_O && RESP_UNDEF_O && RESP_RDATA_O == 64'h0);
	endproperty
	a_user_undef: assert property (p_user_undef)
		else $error("user level access not undefined");

	property p_kernel_virt_undef;
		(REQ_VALID_I && (is_vdefer || is_vsynd) && REQ_LEVEL_I == vesr_pkg::LVL_KERNEL)
			|=> RESP_UNDEF_O;
	endproperty
	a_kernel_virt_undef: assert property (p_kernel_virt_undef)
		else $error("kernel access to virtual register not undefined");

	property p_defer_flag;
		(ESB_DEFER_I && RAS_PRESENT_I) |=> (VDEFER_FLAG_O && st.vdefer_syn == $past(fmt_bus.defer_syn));
	endproperty
	a_defer_flag: assert property (p_defer_flag)
		else $error("deferral did not set flag with captured syndrome");

	property p_short_code;
		(ESB_DEFER_I && RAS_PRESENT_I && !GUEST_AA64_I && !GUEST_LONG_DESC_I)
			|=> ({st.vdefer_syn[10], st.vdefer_syn[3:0]} == vesr_pkg::FS_SHORT
			&& st.vdefer_syn[5:4] == 2'h0 && !st.vdefer_syn[9]);
	endproperty
	a_short_code: assert property (p_short_code)
		else $error("short descriptor fault code wrong");

	property p_long_code;
		(ESB_DEFER_I && RAS_PRESENT_I && !GUEST_AA64_I && GUEST_LONG_DESC_I)
			|=> (st.vdefer_syn[5:0] == vesr_pkg::STATUS_LONG && !st.vdefer_syn[10]
			&& st.vdefer_syn[9]);
	endproperty
	a_long_code: assert property (p_long_code)
		else $error("long descriptor status code wrong");

	property p_no_ras_undef;
		(REQ_VALID_I && req_mine && !RAS_PRESENT_I) |=> (RESP_UNDEF_O && !REC_WR_O);
	endproperty
	a_no_ras_undef: assert property (p_no_ras_undef)
		else $error("access without reliability support not undefined");

	property p_mon_raz;
		(REQ_VALID_I && RAS_PRESENT_I && (is_vdefer || is_vsynd) && !HYP_PRESENT_I
			&& REQ_LEVEL_I == vesr_pkg::LVL_MON) |=> (RESP_RDATA_O == 64'h0 && !RESP_UNDEF_O);
	endproperty
	a_mon_raz: assert property (p_mon_raz)
		else $error("virtual register not zero at monitor without hypervisor");

	property p_read_after_defer;
		(ESB_DEFER_I && RAS_PRESENT_I && REQ_VALID_I && redirect && !REQ_WRITE_I)
			|=> RESP_RDATA_O[vesr_pkg::DEFER_FLAG_BIT];
	endproperty
	a_read_after_defer: assert property (p_read_after_defer)
		else $error("read in deferral cycle missed the flag");

	property p_redirect;
		(REQ_VALID_I && RAS_PRESENT_I && redirect && !REQ_WRITE_I && !ESB_DEFER_I)
			|=> (!RESP_MISS_O && !RESP_UNDEF_O && RESP_RDATA_O[31] == $past(st.vdefer_flag)
			&& RESP_RDATA_O[24:0] == $past(st.vdefer_syn));
	endproperty
	a_redirect: assert property (p_redirect)
		else $error("redirected deferred status read did not return virtual copy");

	property p_miss;
		(REQ_VALID_I && !req_mine)
			|=> (RESP_VALID_O && RESP_MISS_O && !RESP_UNDEF_O && RESP_RDATA_O == 64'h0);
	endproperty
	a_miss: assert property (p_miss)
		else $error("foreign encoding not reported as miss");

	property p_exc_wide;
		(VSERR_TAKE_I && GUEST_AA64_I)
			|=> (EXC_VALID_O && EXC_ESR_SYN_O == $past(st.vsynd) && EXC_DATA_FAULT_STATUS_REG_O == 32'h0);
	endproperty
	a_exc_wide: assert property (p_exc_wide)
		else $error("wide guest exception syndrome not copied");

	property p_exc_narrow;
		(VSERR_TAKE_I && !GUEST_AA64_I)
			|=> (EXC_VALID_O && EXC_ESR_SYN_O == 25'h0000000
			&& EXC_DATA_FAULT_STATUS_REG_O[15:14] == $past(st.vsynd[15:14])
			&& EXC_DATA_FAULT_STATUS_REG_O[12] == $past(st.vsynd[12]));
	endproperty
	a_exc_narrow: assert property (p_exc_narrow)
		else $error("narrow guest fault status not copied");
endmodule
`default_nettype wire

//--- testbench/vesr_tb_top.sv
// Self-checking bench for the virtual error syndrome register block
`timescale 1ns/100ps
`default_nettype none
module vesr_tb_top;
	typedef struct packed {logic [63:0] d; logic [5:0] f;} vesr_exp_t;
	localparam logic [5:0] F_WR = 6'h01;
	localparam logic [5:0] F_UD = 6'h02;
	localparam logic [5:0] F_TH = 6'h04;
	localparam logic [5:0] F_TM = 6'h08;
	localparam logic [5:0] F_MS = 6'h10;
	localparam logic [13:0] VS = vesr_pkg::ENC_VSYND;
	localparam logic [13:0] VD = vesr_pkg::ENC_VDEFER;
	localparam logic [13:0] PD = vesr_pkg::ENC_PDEFER;
	localparam logic [13:0] SV = vesr_pkg::ENC_STATUS_VIEW;
	localparam logic [1:0] US = vesr_pkg::LVL_USER;
	localparam logic [1:0] KL = vesr_pkg::LVL_KERNEL;
	localparam logic [1:0] HY = vesr_pkg::LVL_HYP;
	localparam logic [1:0] MO = vesr_pkg::LVL_MON;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ras = 1'b0, hyp = 1'b1, mon = 1'b1, htrap = 1'b0, mtrap = 1'b0;
	logic route = 1'b0, aa64 = 1'b1, ldesc = 1'b0;
	logic rv = 1'b0, rw = 1'b0, ra32 = 1'b0, defer = 1'b0, take = 1'b0;
	logic [1:0] lvl = 2'h0;
	logic [13:0] enc = 14'h0000;
	logic [63:0] wd = 64'h0, rec = 64'h0;
	logic [15:0] sel = 16'h0002;
	logic [16:0] cnt = 17'h00004;
	logic ns = 1'b1;
	logic [1:0] op0 = vesr_pkg::OP0_SYSREG;
	logic [3:0] cp = vesr_pkg::COPROC_SYSREG;
	logic resp_v, undef, th, tm, miss, rec_wr, vflag, exc_v;
	logic [63:0] rdata, rec_wd;
	logic [15:0] rec_ix;
	logic [24:0] esr;
	logic [31:0] data_fault_status_reg;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	vesr_exp_t exp_q[$];
	vesr_exp_t e;
	logic [56:0] exc_q[$];
	logic [56:0] x;
	logic [31:0] seed = 32'h51185AB5;
	logic [24:0] vs = 25'h0;
	logic flag = 1'b0;

	always #20 clk = ~clk;

	vesr_core uut (.CLOCK_I(clk), .NRST_I(nrst), .RAS_PRESENT_I(ras), .HYP_PRESENT_I(hyp),
		.MON_PRESENT_I(mon), .HYP_ERROR_REG_TRAP_I(htrap), .MONITOR_ERROR_REG_TRAP_I(mtrap),
		.HYP_ASYNC_ABORT_ROUTE_I(route), .GUEST_AA64_I(aa64), .GUEST_LONG_DESC_I(ldesc),
		.REQ_VALID_I(rv), .REQ_WRITE_I(rw), .REQ_AA32_I(ra32),
		.REQ_OP0_I(op0), .REQ_CP_I(cp),
		.REQ_ENC_I(enc), .REQ_LEVEL_I(lvl), .REQ_NONSECURE_I(ns), .REQ_WDATA_I(wd),
		.RESP_VALID_O(resp_v), .RESP_RDATA_O(rdata), .RESP_UNDEF_O(undef),
		.RESP_TRAP_HYP_O(th), .RESP_TRAP_MON_O(tm), .RESP_MISS_O(miss),
		.RECORD_SELECTOR_I(sel), .RECORD_COUNT_I(cnt), .REC_RDATA_I(rec),
		.REC_WR_O(rec_wr), .REC_INDEX_O(rec_ix), .REC_WDATA_O(rec_wd),
		.ESB_DEFER_I(defer), .VSERR_TAKE_I(take), .VDEFER_FLAG_O(vflag),
		.EXC_VALID_O(exc_v), .EXC_ESR_SYN_O(esr), .EXC_DATA_FAULT_STATUS_REG_O(data_fault_status_reg));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [63:0] rnd();
		logic [63:0] r;
		for (int i = 0; i < 64; i++) begin
			seed = lfsr(seed);
			r[i] = seed[0];
		end
		return r;
	endfunction

	// Deferred syndrome as the guest state lays it out
	function automatic logic [24:0] fmt(input logic [24:0] v);
		if (aa64) return v;
		return (v & 25'h000D000) | (ldesc ? 25'h0000211 : 25'h0000406);
	endfunction

	task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
		samples_checked++;
		if (got !== ex) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// Also idles the request port and event pulses
	task automatic cfg(input logic [7:0] c);
		@(posedge clk);
		{ras, hyp, mon, htrap, mtrap, route, aa64, ldesc} <= c;
		rv <= 1'b0;
		defer <= 1'b0;
		take <= 1'b0;
	endtask

	// Back-to-back capable: valid stays high across consecutive calls
	task automatic req(input logic w, input logic a32, input logic [13:0] en,
			input logic [1:0] lv, input logic [63:0] d, input logic [63:0] ed,
			input logic [5:0] ef, input logic [1:0] ev);
		@(posedge clk);
		rv <= 1'b1;
		rw <= w;
		ra32 <= a32;
		enc <= en;
		lvl <= lv;
		wd <= d;
		defer <= ev[0];
		take <= ev[1];
		if (ev[0]) flag = 1'b1;
		if (ev[1]) exc_q.push_back(aa64 ? {vs, 32'h0} : {25'h0, 7'h0, fmt(vs)});
		exp_q.push_back(vesr_exp_t'({ed, ef | {flag, 5'h00}}));
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Output watchers
	// ----------------------------------------
	always @(negedge clk) begin
		if (nrst && resp_v === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("response", 64'h0, 64'h1);
			end else begin
				e = exp_q.pop_front();
				chk("rdata", e.f[0] ? 64'h0 : e.d, rdata);
				chk("flags", {58'h0, e.f}, {58'h0, vflag, miss, tm, th, undef, rec_wr});
				if (e.f[0]) begin
					chk("rec index", {48'h0, sel}, {48'h0, rec_ix});
					chk("rec data", e.d, rec_wd);
				end
			end
		end
		if (nrst && exc_v === 1'b1) begin
			x = (exc_q.size() == 0) ? 57'h1FFFFFFFFFFFFFF : exc_q.pop_front();
			chk("exc syndrome", {39'h0, x[56:32]}, {39'h0, esr});
			chk("exc fault status", {32'h0, x[31:0]}, {32'h0, data_fault_status_reg});
		end
	end

	// Whole run is under a hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			$display("unexpected timeout expected done seen hang");
			summarize();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [63:0] r;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		req(1'b0, 1'b0, VS, HY, 64'h0, 64'h0, F_UD, 2'h0);
		cfg(8'hE2);
		$display("test absent done");
		r = rnd();
		req(1'b1, 1'b0, VS, HY, r, 64'h0, 6'h0, 2'h0);
		vs = r[24:0];
		req(1'b0, 1'b0, VS, HY, 64'h0, {39'h0, vs}, 6'h0, 2'h0);
		req(1'b0, 1'b1, VS, HY, 64'h0, {39'h0, vs}, 6'h0, 2'h0);
		for (int i = 0; i < 4; i++) begin
			req(i[0], 1'b0, i[1] ? VD : VS, {1'b0, i[0]}, rnd(), 64'h0, F_UD, 2'h0);
		end
		req(1'b0, 1'b0, VD, HY, 64'h0, {32'h0, 1'b1, 6'h0, fmt(vs)}, 6'h0, 2'h1);
		req(1'b0, 1'b0, VS, HY, 64'h0, {39'h0, vs}, 6'h0, 2'h2);
		cfg(8'hE6);
		req(1'b0, 1'b0, PD, KL, 64'h0, {32'h0, 1'b1, 6'h0, vs}, 6'h0, 2'h0);
		flag = 1'b0;
		req(1'b1, 1'b1, PD, KL, 64'h0, 64'h0, 6'h0, 2'h0);
		req(1'b0, 1'b0, VD, HY, 64'h0, 64'h0, 6'h0, 2'h0);
		cfg(8'hE2);
		req(1'b0, 1'b0, PD, KL, 64'h0, 64'h0, F_MS, 2'h0);
		cfg(8'hE2);
		op0 <= 2'h2;
		cp <= 4'hE;
		req(1'b0, 1'b0, VS, HY, 64'h0, 64'h0, F_MS, 2'h0);
		req(1'b0, 1'b1, VS, HY, 64'h0, 64'h0, F_MS, 2'h0);
		$display("test wide guest done");
		for (int l = 0; l < 2; l++) begin
			cfg({6'b111000, 1'b0, l[0]});
			op0 <= vesr_pkg::OP0_SYSREG;
			cp <= vesr_pkg::COPROC_SYSREG;
			r = rnd();
			req(1'b1, 1'b1, VS, HY, r, 64'h0, 6'h0, 2'h0);
			vs = r[24:0] & 25'h000D000;
			req(1'b0, 1'b0, VS, HY, 64'h0, {39'h0, vs}, 6'h0, 2'h0);
			req(1'b0, 1'b0, VD, HY, 64'h0, {32'h0, 1'b1, 6'h0, fmt(vs)}, 6'h0, 2'h1);
			req(1'b0, 1'b0, VS, HY, 64'h0, {39'h0, vs}, 6'h0, 2'h2);
		end
		$display("test narrow guest done");
		cfg(8'hE2);
		r = rnd();
		rec <= r;
		req(1'b0, 1'b0, SV, KL, 64'h0, r, 6'h0, 2'h0);
		r = rnd();
		req(1'b1, 1'b0, SV, KL, r, r, F_WR, 2'h0);
		req(1'b0, 1'b0, SV, US, 64'h0, 64'h0, F_UD, 2'h0);
		cfg(8'hF2);
		req(1'b0, 1'b0, SV, KL, 64'h0, 64'h0, F_TH, 2'h0);
		cfg(8'hFA);
		req(1'b0, 1'b0, SV, HY, 64'h0, 64'h0, F_TM, 2'h0);
		req(1'b1, 1'b0, SV, KL, rnd(), 64'h0, F_TH, 2'h0);
		cfg(8'hFA);
		ns <= 1'b0;
		req(1'b0, 1'b0, SV, KL, 64'h0, 64'h0, F_TM, 2'h0);
		cfg(8'hF2);
		req(1'b0, 1'b0, SV, KL, 64'h0, rec, 6'h0, 2'h0);
		cfg(8'hE2);
		ns <= 1'b1;
		sel <= 16'h0004;
		req(1'b1, 1'b0, SV, KL, rnd(), 64'h0, 6'h0, 2'h0);
		req(1'b0, 1'b0, SV, KL, 64'h0, 64'h0, 6'h0, 2'h0);
		cfg(8'hE2);
		cnt <= 17'h00000;
		sel <= 16'h0000;
		req(1'b0, 1'b0, SV, KL, 64'h0, 64'h0, 6'h0, 2'h0);
		$display("test status view done");
		cfg(8'hA2);
		req(1'b0, 1'b0, VS, MO, 64'h0, 64'h0, 6'h0, 2'h0);
		req(1'b0, 1'b0, VD, MO, 64'h0, 64'h0, 6'h0, 2'h0);
		cfg(8'hE2);
		repeat (3) @(posedge clk);
		$display("test no hypervisor done");
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		flag = 1'b0;
		chk("reset outputs", 64'h0, {61'h0, vflag, resp_v, exc_v});
		req(1'b0, 1'b0, VD, HY, 64'h0, 64'h0, 6'h0, 2'h0);
		req(1'b0, 1'b0, VS, HY, 64'h0, 64'h0, 6'h0, 2'h0);
		cfg(8'hE2);
		repeat (2) @(posedge clk);
		$display("test reset done");
		chk("pending", 64'h0, 64'(exp_q.size() + exc_q.size()));
		summarize();
	end
endmodule
`default_nettype wire
